//--- pkg/pwu_pkg.sv
// register map, field layout and bus carrier for the pwm output unit
package pwu_pkg;
    localparam int PWU_NGEN = 3;
    localparam int PWU_CW   = 16;
    localparam int PWU_DBW  = 12;
    localparam int PWU_NEV  = 6;

    // global register offsets (byte addresses)
    localparam logic [7:0] PWU_A_CTL    = 8'h00;
    localparam logic [7:0] PWU_A_SYNC   = 8'h04;
    localparam logic [7:0] PWU_A_ENABLE = 8'h08;
    localparam logic [7:0] PWU_A_INVERT = 8'h0C;
    localparam logic [7:0] PWU_A_FAULT  = 8'h10;
    localparam logic [7:0] PWU_A_INTEN  = 8'h14;
    localparam logic [7:0] PWU_A_RIS    = 8'h18;
    localparam logic [7:0] PWU_A_ISC    = 8'h1C;
    localparam logic [7:0] PWU_A_STATUS = 8'h20;

    // per-generator offsets inside a 0x40 block starting at 0x40
    localparam logic [5:0] PWU_G_CTL    = 6'h00;
    localparam logic [5:0] PWU_G_INTEN  = 6'h04;
    localparam logic [5:0] PWU_G_RIS    = 6'h08;
    localparam logic [5:0] PWU_G_ISC    = 6'h0C;
    localparam logic [5:0] PWU_G_LOAD   = 6'h10;
    localparam logic [5:0] PWU_G_COUNT  = 6'h14;
    localparam logic [5:0] PWU_G_CMPA   = 6'h18;
    localparam logic [5:0] PWU_G_CMPB   = 6'h1C;
    localparam logic [5:0] PWU_G_GENA   = 6'h20;
    localparam logic [5:0] PWU_G_GENB   = 6'h24;
    localparam logic [5:0] PWU_G_DBCTL  = 6'h28;
    localparam logic [5:0] PWU_G_DBRISE = 6'h2C;
    localparam logic [5:0] PWU_G_DBFALL = 6'h30;

    // generator control bits
    localparam int PWU_C_EN     = 0;
    localparam int PWU_C_UPDN   = 1;
    localparam int PWU_C_DBGRUN = 2;
    localparam int PWU_C_LDSYNC = 3;
    localparam int PWU_C_CASYNC = 4;
    localparam int PWU_C_CBSYNC = 5;
    localparam int PWU_C_W      = 6;

    // event bit positions; action fields are two bits per event
    localparam int PWU_EV_ZERO = 0;
    localparam int PWU_EV_LOAD = 1;
    localparam int PWU_EV_AUP  = 2;
    localparam int PWU_EV_ADN  = 3;
    localparam int PWU_EV_BUP  = 4;
    localparam int PWU_EV_BDN  = 5;
    localparam int PWU_TRIG_LSB = 8;   // trigger select field in gen inten
    localparam int PWU_FAULT_BIT = 16; // fault bit in global inten/ris/isc

    localparam logic [1:0] PWU_ACT_HOLD = 2'h0;
    localparam logic [1:0] PWU_ACT_TOG  = 2'h1;
    localparam logic [1:0] PWU_ACT_LOW  = 2'h2;
    localparam logic [1:0] PWU_ACT_HIGH = 2'h3;

    localparam logic [31:0] PWU_RST = 32'h0000_0000;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pwu_wb_req_t;
endpackage : pwu_pkg

//--- hdl/pwu_top.sv
// pwm output unit: generators, dead-band, output control, wishbone slave
`timescale 1ns/1ns

// Function
// - down mode: zero, load, A down, B down
// - up/down mode: six events, the four compares direction-qualified
// - compare match dropped on zero/load cycle
// - coincident matches: A uses A, B uses B
// - per-event action: hold, toggle, low, high
// - dead-band off passes both signals
// - dead-band on: first delays rising edge
// - second is inverse, delayed after falling edge
// - interrupt on any selected event
// - trigger pulse on separately selected events
// - interrupt/trigger use raw counter events
// - resync resets chosen counters one cycle after the write
// - immediate update applies at next zero
// - sync update waits global update, then zero
// - update mode per load and compare value
// - per-output fault bit forces inactive
// - fault raises a processor interrupt
// - stall: keep running or halt at zero
// - stall raises no interrupt
// - one enable register gates all pins
// - per-output final inversion
// - count down reload, or up and down
// - down mode: load pulse follows zero
// - compare above load never matches
// - resync bits self-clear after reset
module pwu_top
    import pwu_pkg::*;
#(
    parameter int NGEN = PWU_NGEN,
    parameter int CW   = PWU_CW,
    parameter int DBW  = PWU_DBW
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire pwu_wb_req_t      wb_req,
    output logic                  wb_ack,
    output logic [31:0]           wb_dat_o,
    input  wire logic             fault_in,
    input  wire logic             dbg_stall,
    output logic [2*NGEN-1:0]     pwm_pin,
    output logic [NGEN-1:0]       adc_trig,
    output logic                  irq
);
    localparam int NO = 2 * NGEN;

    // register state
    logic [PWU_C_W-1:0] ctl_q  [NGEN];
    logic [13:0]        inten_q[NGEN];
    logic [PWU_NEV-1:0] ris_q  [NGEN];
    logic [CW-1:0]      cnt_q  [NGEN];
    logic [CW-1:0]      ldw_q  [NGEN];
    logic [CW-1:0]      ld_q   [NGEN];
    logic [CW-1:0]      caw_q  [NGEN];
    logic [CW-1:0]      ca_q   [NGEN];
    logic [CW-1:0]      cbw_q  [NGEN];
    logic [CW-1:0]      cb_q   [NGEN];
    logic [11:0]        gena_q [NGEN];
    logic [11:0]        genb_q [NGEN];
    logic [DBW-1:0]     dbr_q  [NGEN];
    logic [DBW-1:0]     dbf_q  [NGEN];
    logic [DBW-1:0]     dcr_q  [NGEN];
    logic [DBW-1:0]     dcf_q  [NGEN];
    logic [NGEN-1:0]    dben_q, dir_q, hold_q, sa_q, sb_q, gsync_q, sync_q;
    logic [NO-1:0]      enable_q, invert_q, flten_q;
    logic [31:0]        ginten_q;
    logic               flt_q;

    // combinational per-generator values
    logic [PWU_NEV-1:0] ev   [NGEN];
    logic [CW-1:0]      nl   [NGEN];
    logic [NGEN-1:0]    act_g, zr, sa_d, sb_d, dba, dbb, upl, upa, upb, gint;
    logic [31:0]        gris, rd;
    logic               acc, wr;
    logic [31:0]        wd;
    logic [1:0]         gidx;
    logic [5:0]         go;

    // apply one programmed action to a level
    function automatic logic act_f(input logic v, input logic [1:0] a);
        case (a)
            PWU_ACT_TOG:  act_f = ~v;
            PWU_ACT_LOW:  act_f = 1'b0;
            PWU_ACT_HIGH: act_f = 1'b1;
            default:      act_f = v;
        endcase
    endfunction : act_f

    // two-bit action field of an event
    function automatic logic [1:0] fld_f(input logic [11:0] r, input int e);
        fld_f = r[2*e +: 2];
    endfunction : fld_f

    // byte-lane merge of write data into the addressed register
    function automatic logic [31:0] wrm_f(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            wrm_f[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
        end
    endfunction : wrm_f

    // bus decode
    assign acc  = wb_req.cyc & wb_req.stb & ~wb_ack;
    assign wr   = acc & wb_req.we;
    assign gidx = wb_req.adr[7:6];
    assign go   = {wb_req.adr[5:2], 2'b00};
    assign wd   = wrm_f(rd, wb_req.dat, wb_req.sel);

    // events, update selection, action and dead-band paths
    always_comb begin
        gris = PWU_RST;
        for (int g = 0; g < NGEN; g++) begin
            logic ma, mb, up, a, b;
            ma = 1'b0;
            mb = 1'b0;
            up = 1'b0;
            a  = 1'b0;
            b  = 1'b0;
            act_g[g] = ctl_q[g][PWU_C_EN] & ~hold_q[g];
            zr[g]    = cnt_q[g] == '0;
            upl[g]   = ~ctl_q[g][PWU_C_LDSYNC] | gsync_q[g];
            upa[g]   = ~ctl_q[g][PWU_C_CASYNC] | gsync_q[g];
            upb[g]   = ~ctl_q[g][PWU_C_CBSYNC] | gsync_q[g];
            nl[g]    = upl[g] ? ldw_q[g] : ld_q[g];
            ma = act_g[g] & (cnt_q[g] == ca_q[g]) & (ca_q[g] <= ld_q[g]);
            mb = act_g[g] & (cnt_q[g] == cb_q[g]) & (cb_q[g] <= ld_q[g]);
            up = ctl_q[g][PWU_C_UPDN] & dir_q[g];
            ev[g][PWU_EV_ZERO] = act_g[g] & zr[g];
            ev[g][PWU_EV_LOAD] = act_g[g] & (cnt_q[g] == ld_q[g]);
            ev[g][PWU_EV_AUP]  = ma & up;
            ev[g][PWU_EV_ADN]  = ma & ~up;
            ev[g][PWU_EV_BUP]  = mb & up;
            ev[g][PWU_EV_BDN]  = mb & ~up;
            // zero then load actions, then compares unless masked by them
            a = sa_q[g];
            b = sb_q[g];
            for (int e = PWU_EV_ZERO; e <= PWU_EV_LOAD; e++) begin
                if (ev[g][e]) begin
                    a = act_f(a, fld_f(gena_q[g], e));
                    b = act_f(b, fld_f(genb_q[g], e));
                end
            end
            if (!(ev[g][PWU_EV_ZERO] | ev[g][PWU_EV_LOAD])) begin
                if (ma) begin
                    a = act_f(a, fld_f(gena_q[g], up ? PWU_EV_AUP : PWU_EV_ADN));
                end else if (mb) begin
                    a = act_f(a, fld_f(gena_q[g], up ? PWU_EV_BUP : PWU_EV_BDN));
                end
                if (mb) begin
                    b = act_f(b, fld_f(genb_q[g], up ? PWU_EV_BUP : PWU_EV_BDN));
                end else if (ma) begin
                    b = act_f(b, fld_f(genb_q[g], up ? PWU_EV_AUP : PWU_EV_ADN));
                end
            end
            sa_d[g] = a;
            sb_d[g] = b;
            // dead-band: delayed rise on first, delayed inverse on second
            dba[g] = dben_q[g] ? (sa_q[g] & (dcr_q[g] >= dbr_q[g])) : sa_q[g];
            dbb[g] = dben_q[g] ? (~sa_q[g] & (dcf_q[g] >= dbf_q[g])) : sb_q[g];
            gint[g] = |(ris_q[g] & inten_q[g][PWU_NEV-1:0]);
            gris[g] = gint[g];
        end
        gris[PWU_FAULT_BIT] = flt_q;
    end

    // register read mux
    always_comb begin
        rd = PWU_RST;
        if (gidx == 2'h0) begin
            case (wb_req.adr)
                PWU_A_CTL:    rd[NGEN-1:0] = gsync_q;
                PWU_A_SYNC:   rd[NGEN-1:0] = sync_q;
                PWU_A_ENABLE: rd[NO-1:0]   = enable_q;
                PWU_A_INVERT: rd[NO-1:0]   = invert_q;
                PWU_A_FAULT:  rd[NO-1:0]   = flten_q;
                PWU_A_INTEN:  rd           = ginten_q;
                PWU_A_RIS:    rd           = gris;
                PWU_A_ISC:    rd           = gris & ginten_q;
                PWU_A_STATUS: rd[0]        = fault_in;
                default:      rd           = PWU_RST;
            endcase
        end else if (int'(gidx) <= NGEN) begin
            case (go)
                PWU_G_CTL:    rd[PWU_C_W-1:0] = ctl_q[gidx-2'h1];
                PWU_G_INTEN:  rd[13:0]        = inten_q[gidx-2'h1];
                PWU_G_RIS:    rd[PWU_NEV-1:0] = ris_q[gidx-2'h1];
                PWU_G_ISC:    rd[PWU_NEV-1:0] = ris_q[gidx-2'h1] & inten_q[gidx-2'h1][PWU_NEV-1:0];
                PWU_G_LOAD:   rd[CW-1:0]      = ldw_q[gidx-2'h1];
                PWU_G_COUNT:  rd[CW-1:0]      = cnt_q[gidx-2'h1];
                PWU_G_CMPA:   rd[CW-1:0]      = caw_q[gidx-2'h1];
                PWU_G_CMPB:   rd[CW-1:0]      = cbw_q[gidx-2'h1];
                PWU_G_GENA:   rd[11:0]        = gena_q[gidx-2'h1];
                PWU_G_GENB:   rd[11:0]        = genb_q[gidx-2'h1];
                PWU_G_DBCTL:  rd[0]           = dben_q[gidx-2'h1];
                PWU_G_DBRISE: rd[DBW-1:0]     = dbr_q[gidx-2'h1];
                PWU_G_DBFALL: rd[DBW-1:0]     = dbf_q[gidx-2'h1];
                default:      rd              = PWU_RST;
            endcase
        end
    end

    // wishbone answer: ack one cycle after the request, data with it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack   <= 1'b0;
            wb_dat_o <= PWU_RST;
        end else if (ce) begin
            wb_ack   <= acc;
            wb_dat_o <= acc ? rd : PWU_RST;
        end
    end

    // global control registers and fault sticky bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_q <= '0;
            invert_q <= '0;
            flten_q  <= '0;
            ginten_q <= PWU_RST;
            flt_q    <= 1'b0;
        end else if (ce) begin
            if (wr && wb_req.adr == PWU_A_ENABLE) enable_q <= wd[NO-1:0];
            if (wr && wb_req.adr == PWU_A_INVERT) invert_q <= wd[NO-1:0];
            if (wr && wb_req.adr == PWU_A_FAULT)  flten_q  <= wd[NO-1:0];
            if (wr && wb_req.adr == PWU_A_INTEN)  ginten_q <= wd;
            // fault latch, set wins over write-one-to-clear
            flt_q <= fault_in | (flt_q & ~(wr && wb_req.adr == PWU_A_ISC && wb_req.dat[PWU_FAULT_BIT]));
        end
    end

    // per-generator configuration, shadow values and status
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int g = 0; g < NGEN; g++) begin
                ctl_q[g]   <= '0;
                inten_q[g] <= '0;
                ris_q[g]   <= '0;
                ldw_q[g]   <= '0;
                ld_q[g]    <= '0;
                caw_q[g]   <= '0;
                ca_q[g]    <= '0;
                cbw_q[g]   <= '0;
                cb_q[g]    <= '0;
                gena_q[g]  <= '0;
                genb_q[g]  <= '0;
                dbr_q[g]   <= '0;
                dbf_q[g]   <= '0;
            end
            dben_q  <= '0;
            gsync_q <= '0;
            sync_q  <= '0;
        end else if (ce) begin
            for (int g = 0; g < NGEN; g++) begin
                if (wr && gidx == 2'(g + 1)) begin
                    case (go)
                        PWU_G_CTL:    ctl_q[g]   <= wd[PWU_C_W-1:0];
                        PWU_G_INTEN:  inten_q[g] <= wd[13:0];
                        PWU_G_LOAD:   ldw_q[g]   <= wd[CW-1:0];
                        PWU_G_CMPA:   caw_q[g]   <= wd[CW-1:0];
                        PWU_G_CMPB:   cbw_q[g]   <= wd[CW-1:0];
                        PWU_G_GENA:   gena_q[g]  <= wd[11:0];
                        PWU_G_GENB:   genb_q[g]  <= wd[11:0];
                        PWU_G_DBCTL:  dben_q[g]  <= wd[0];
                        PWU_G_DBRISE: dbr_q[g]   <= wd[DBW-1:0];
                        PWU_G_DBFALL: dbf_q[g]   <= wd[DBW-1:0];
                        default:      ;
                    endcase
                end
                // raw event latch; new events win over clear
                ris_q[g] <= ev[g] | (ris_q[g] &
                    ~((wr && gidx == 2'(g + 1) && go == PWU_G_ISC) ? wb_req.dat[PWU_NEV-1:0] : '0));
                // shadows reach the active copies only at counter zero
                if (ev[g][PWU_EV_ZERO]) begin
                    if (upl[g]) ld_q[g] <= ldw_q[g];
                    if (upa[g]) ca_q[g] <= caw_q[g];
                    if (upb[g]) cb_q[g] <= cbw_q[g];
                end
                // global update and resync requests self-clear
                if (wr && wb_req.adr == PWU_A_CTL && wd[g]) begin
                    gsync_q[g] <= 1'b1;
                end else if (ev[g][PWU_EV_ZERO]) begin
                    gsync_q[g] <= 1'b0;
                end
                sync_q[g] <= wr && wb_req.adr == PWU_A_SYNC && wd[g];
            end
        end
    end

    // counters, direction and debug hold
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int g = 0; g < NGEN; g++) cnt_q[g] <= '0;
            dir_q  <= '0;
            hold_q <= '0;
        end else if (ce) begin
            for (int g = 0; g < NGEN; g++) begin
                hold_q[g] <= dbg_stall & (hold_q[g] |
                    (~ctl_q[g][PWU_C_DBGRUN] & ev[g][PWU_EV_ZERO]));
                if (sync_q[g]) begin
                    cnt_q[g] <= '0;
                    dir_q[g] <= 1'b1;
                end else if (act_g[g] && !(dbg_stall && !ctl_q[g][PWU_C_DBGRUN] && zr[g])) begin
                    if (!ctl_q[g][PWU_C_UPDN]) begin
                        cnt_q[g] <= zr[g] ? nl[g] : CW'(cnt_q[g] - 1'b1);
                    end else if (dir_q[g]) begin
                        if (cnt_q[g] >= ld_q[g]) begin
                            dir_q[g] <= 1'b0;
                            cnt_q[g] <= zr[g] ? cnt_q[g] : CW'(cnt_q[g] - 1'b1);
                        end else begin
                            cnt_q[g] <= CW'(cnt_q[g] + 1'b1);
                        end
                    end else if (zr[g]) begin
                        dir_q[g] <= 1'b1;
                        cnt_q[g] <= (nl[g] == '0) ? cnt_q[g] : CW'(cnt_q[g] + 1'b1);
                    end else begin
                        cnt_q[g] <= CW'(cnt_q[g] - 1'b1);
                    end
                end
            end
        end
    end

    // generator signal levels and dead-band delay counters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sa_q <= '0;
            sb_q <= '0;
            for (int g = 0; g < NGEN; g++) begin
                dcr_q[g] <= '0;
                dcf_q[g] <= '0;
            end
        end else if (ce) begin
            sa_q <= sa_d;
            sb_q <= sb_d;
            for (int g = 0; g < NGEN; g++) begin
                if (!sa_q[g]) dcr_q[g] <= '0;
                else if (dcr_q[g] < dbr_q[g]) dcr_q[g] <= DBW'(dcr_q[g] + 1'b1);
                if (sa_q[g]) dcf_q[g] <= '0;
                else if (dcf_q[g] < dbf_q[g]) dcf_q[g] <= DBW'(dcf_q[g] + 1'b1);
            end
        end
    end

    // output control, triggers and interrupt line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_pin  <= '0;
            adc_trig <= '0;
            irq      <= 1'b0;
        end else if (ce) begin
            for (int g = 0; g < NGEN; g++) begin
                pwm_pin[2*g]   <= (dba[g] & ~(fault_in & flten_q[2*g]) & enable_q[2*g])
                                  ^ invert_q[2*g];
                pwm_pin[2*g+1] <= (dbb[g] & ~(fault_in & flten_q[2*g+1]) & enable_q[2*g+1])
                                  ^ invert_q[2*g+1];
                adc_trig[g]    <= |(ev[g] & inten_q[g][PWU_TRIG_LSB +: PWU_NEV]);
            end
            irq <= |(gris & ginten_q);
        end
    end
endmodule : pwu_top

//--- dv/pwu_checker.sv
// port-level assertion checker for the pwm output unit
`timescale 1ns/1ns
module pwu_checker
    import pwu_pkg::*;
#(
    parameter int NGEN = PWU_NGEN
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              ce,
    input wire pwu_wb_req_t       wb_req,
    input wire logic              wb_ack,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              fault_in,
    input wire logic              dbg_stall,
    input wire logic [2*NGEN-1:0] pwm_pin,
    input wire logic [NGEN-1:0]   adc_trig,
    input wire logic              irq
);
    logic              take;
    logic [2*NGEN-1:0] flt_q, inv_q, en_q;
    logic [NGEN-1:0]   gie_q;
    logic              fie_q, trg_q;
    // request accepted by the slave on this edge
    assign take = wb_req.cyc && wb_req.stb && !wb_ack && ce;
    // shadow of output control, interrupt enable and trigger select writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {flt_q, inv_q, en_q, gie_q, fie_q, trg_q} <= '0;
        end else if (take && wb_req.we && wb_req.sel[0]) begin
            if (wb_req.adr == PWU_A_FAULT) flt_q <= wb_req.dat[2*NGEN-1:0];
            if (wb_req.adr == PWU_A_INVERT) inv_q <= wb_req.dat[2*NGEN-1:0];
            if (wb_req.adr == PWU_A_ENABLE) en_q <= wb_req.dat[2*NGEN-1:0];
            if (wb_req.adr == PWU_A_INTEN) gie_q <= wb_req.dat[NGEN-1:0];
            if (wb_req.adr == PWU_A_INTEN) fie_q <= wb_req.dat[PWU_FAULT_BIT];
            if (wb_req.adr[7:6] != 2'h0 && wb_req.adr[5:0] == PWU_G_INTEN
                && wb_req.dat[PWU_TRIG_LSB+:PWU_NEV] != '0) trg_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ack_resp; take |=> wb_ack; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    property p_ack_once; wb_ack && ce |=> !wb_ack; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_dat_idle; !wb_ack |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_ce_freeze; !ce |=> $stable(pwm_pin) && $stable(wb_ack) && $stable(irq); endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("outputs moved with clock enable low");
    property p_fault_force; fault_in ##1 (fault_in && $stable(inv_q) && $stable(flt_q)) |-> (pwm_pin & flt_q) == (inv_q & flt_q); endproperty
    a_fault_force: assert property (p_fault_force) else $error("faulted pin not inactive");
    property p_en_gate; (en_q == '0 && $stable(inv_q)) [*3] |-> pwm_pin == inv_q; endproperty
    a_en_gate: assert property (p_en_gate) else $error("disabled pin not at idle level");
    property p_fault_irq; fault_in && fie_q |-> ##[1:3] irq; endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("fault gave no interrupt");
    property p_no_trig; !trg_q [*2] |-> adc_trig == '0; endproperty
    a_no_trig: assert property (p_no_trig) else $error("trigger with no source selected");
    property p_no_irq; (gie_q == '0 && !fie_q) [*3] |-> !irq; endproperty
    a_no_irq: assert property (p_no_irq) else $error("interrupt with none enabled");
endmodule : pwu_checker

bind pwu_top pwu_checker #(.NGEN(NGEN)) u_pwu_checker (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_req(wb_req),
    .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .fault_in(fault_in), .dbg_stall(dbg_stall), .pwm_pin(pwm_pin),
    .adc_trig(adc_trig), .irq(irq));

//--- dv/pwu_gate_model.sv
// half-bridge gate driver and fault source model for generator 0
`timescale 1ns/1ns
module pwu_gate_model (
    input wire logic  clk,
    input wire logic  rst_b,
    input wire logic [1:0] gate,
    input wire logic  fault_req,
    output logic      fault_in,
    output logic [15:0] hi0,
    output logic [15:0] hi1,
    output logic [15:0] per0
);
    logic [15:0] c0_q, c1_q, pc_q;
    logic        g0_q;
    // high-time of both gate lines, period of the first, fault line registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {c0_q, c1_q, pc_q, hi0, hi1, per0, g0_q, fault_in} <= '0;
        end else begin
            g0_q <= gate[0];
            fault_in <= fault_req;
            c0_q <= gate[0] ? c0_q + 16'h1 : 16'h0;
            c1_q <= gate[1] ? c1_q + 16'h1 : 16'h0;
            if (!gate[0] && c0_q != 16'h0) hi0 <= c0_q;
            if (!gate[1] && c1_q != 16'h0) hi1 <= c1_q;
            pc_q <= (gate[0] && !g0_q) ? 16'h1 : pc_q + 16'h1;
            if (gate[0] && !g0_q) per0 <= pc_q;
        end
    end
endmodule : pwu_gate_model

//--- dv/pwu_top_test.sv
// self-checking bench for the pwm output unit
`timescale 1ns/1ns
module pwu_top_test;
    import pwu_pkg::*;
    logic        clk, rst_b, ce, fault_in, dbg_stall, wb_ack, irq, fault_req;
    pwu_wb_req_t wb_req;
    logic [31:0] wb_dat_o, rd;
    logic [5:0]  pwm_pin;
    logic [2:0]  adc_trig;
    logic [15:0] hi0, hi1, per0;
    int          num_errors, samples_checked, n;

    pwu_top u_pwu_top (.clk(clk), .rst_b(rst_b), .ce(ce), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
        .fault_in(fault_in), .dbg_stall(dbg_stall), .pwm_pin(pwm_pin), .adc_trig(adc_trig), .irq(irq));
    pwu_gate_model u_pwu_gate_model (.clk(clk), .rst_b(rst_b), .gate(pwm_pin[1:0]), .fault_req(fault_req),
        .fault_in(fault_in), .hi0(hi0), .hi1(hi1), .per0(per0));

    task close_out;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic wishbone cycle, held until ack is sampled
    task xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        // no cycle count assumed; a hung slave is left to the watchdog
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_dat_o;
        wb_req <= '0;
        @(posedge clk);
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    function automatic logic [7:0] ga(input logic [5:0] off);
        return {2'h1, off};
    endfunction : ga

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog well past the expected run length
    initial begin
        #500000;
        num_errors++;
        close_out;
    end
    initial begin
        {rst_b, dbg_stall, fault_req} = 3'h0;
        ce = 1'b1;
        wb_req = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++) rdc(8'(4 * i), 32'h0);
        wr(8'h24, 32'hFFFF_FFFF);
        rdc(8'h24, 32'h0);
        wr(PWU_A_RIS, 32'hFFFF_FFFF);
        rdc(PWU_A_RIS, 32'h0);
        // down mode, period of twenty ticks
        wr(ga(PWU_G_LOAD), 32'h13);
        wr(ga(PWU_G_CMPA), 32'h5);
        wr(ga(PWU_G_GENA), 32'h83);
        wr(ga(PWU_G_GENB), 32'h404);
        wr(PWU_A_ENABLE, 32'h3);
        wr(ga(PWU_G_CTL), 32'h1);
        rdc(ga(PWU_G_LOAD), 32'h13);
        repeat (60) @(posedge clk);
        chk(32'(per0), 32'h14);
        chk(32'(hi0), 32'hF);
        chk(32'(hi1), 32'h14);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        // complementary pair with dead bands
        wr(ga(PWU_G_DBRISE), 32'h3);
        wr(ga(PWU_G_DBFALL), 32'h2);
        wr(ga(PWU_G_DBCTL), 32'h1);
        repeat (60) @(posedge clk);
        chk(32'(hi0), 32'hC);
        chk(32'(hi1), 32'h3);
        // fault forcing, inversion after forcing, fault interrupt
        wr(PWU_A_FAULT, 32'h3);
        wr(PWU_A_INTEN, 32'h0001_0000);
        fault_req <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(pwm_pin[1:0]), 32'h0);
        chk(32'(irq), 32'h1);
        wr(PWU_A_INVERT, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'(pwm_pin[1:0]), 32'h3);
        fault_req <= 1'b0;
        wr(PWU_A_INVERT, 32'h0);
        wr(PWU_A_ISC, 32'h0001_0000);
        repeat (3) @(posedge clk);
        chk(32'(irq), 32'h0);
        // interrupt and trigger on counter zero
        wr(ga(PWU_G_INTEN), 32'h101);
        wr(PWU_A_INTEN, 32'h1);
        n = 0;
        repeat (40) begin @(posedge clk); n += adc_trig[0]; end
        chk(32'(n), 32'h2);
        chk(32'(irq), 32'h1);
        // up/down mode, then a compare update
        wr(ga(PWU_G_DBCTL), 32'h0);
        wr(ga(PWU_G_LOAD), 32'h9);
        wr(ga(PWU_G_CMPA), 32'h3);
        wr(ga(PWU_G_GENA), 32'hB0);
        wr(ga(PWU_G_CTL), 32'h3);
        repeat (80) @(posedge clk);
        chk(32'(per0), 32'h12);
        chk(32'(hi0), 32'hC);
        chk(32'(hi1), 32'h12);
        wr(ga(PWU_G_CMPA), 32'h5);
        repeat (60) @(posedge clk);
        chk(32'(hi0), 32'h8);
        wr(PWU_A_SYNC, 32'h1);
        rdc(PWU_A_SYNC, 32'h0);
        dbg_stall <= 1'b1;
        repeat (40) @(posedge clk);
        rdc(ga(PWU_G_COUNT), 32'h0);
        dbg_stall <= 1'b0;
        close_out;
    end
endmodule : pwu_top_test
